// *** logic/run_stop_consts.svh ***
// Constants for the run/stop mode controller
`ifndef RUN_STOP_CONSTS_SVH
`define RUN_STOP_CONSTS_SVH
`define CLK_MHZ 100
`define SAMPLE_CYCLE_MS 100
`define QUAL_DELAY_MS 200
`define SET_HOLD_MS 2000
`define OP_SCREEN_COUNT 4
`define RUNSTOP_SCREEN 4'h2
`define EVENT_COUNT 4
`define CTRL_PID 2'h0
`define CTRL_HEATCOOL 2'h1
`define CTRL_POSITION 2'h2
`define MV_RESET 16'h0000
`endif

// *** logic/run_stop_pkg.sv ***
// Types for the run/stop mode controller
package run_stop_pkg;
  typedef struct packed {
    logic set;
    logic shift;
    logic up;
    logic down;
    logic direct;
  } key_type;

  typedef enum logic [0:0] {
    MENU_MONITOR = 1'b0,
    MENU_OPERATION = 1'b1
  } menu_state_type;

  typedef struct packed {
    logic [31:0] div;
    logic sampled;
    logic applied;
    logic [31:0] dly;
    logic waiting;
    logic pending;
  } qual_state_type;

  typedef struct packed {
    key_type keys_prev;
    menu_state_type menu;
    logic [3:0] screen;
    logic [31:0] hold_cnt;
    logic hold_done;
    logic key_run;
    logic run_mode;
    logic resume_pulse;
    logic [1:0] resume_mode;
    logic stop_on_sv;
    logic stop_on_pv;
    logic [15:0] heat_out;
    logic [15:0] cool_out;
    logic valve_follow;
    logic [1:0] valve_action;
    logic [3:0] events;
    logic heater_break_alarm_output;
    logic [15:0] transmission;
  } ctrl_state_type;
endpackage

// *** logic/contact_qualifier.sv ***
// Sampling-cycle divider and run/stop contact qualification delay
`timescale 1ns/1ps
`include "run_stop_consts.svh"
module contact_qualifier
  import run_stop_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLE_MS * 1000 * `CLK_MHZ,
  parameter int DELAY_CYCLES = `QUAL_DELAY_MS * 1000 * `CLK_MHZ
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic contact_in,
  output logic closed_out
);
  qual_state_type s_reg;
  qual_state_type s_next;
  logic tick_now;

  if (SAMPLE_CYCLES < 1 || DELAY_CYCLES < 1) begin : g_chk
    $error("contact_qualifier: counts must be at least one");
  end

  assign tick_now = (s_reg.div == 32'(SAMPLE_CYCLES - 1));
  assign closed_out = s_reg.applied;

  always_comb begin
    s_next = s_reg;
    s_next.div = tick_now ? 32'h0000_0000 : s_reg.div + 32'h0000_0001;
    if (s_reg.waiting) begin
      if (s_reg.dly == 32'(DELAY_CYCLES - 1)) begin
        s_next.waiting = 1'b0;
        s_next.pending = 1'b1;
      end else begin
        s_next.dly = s_reg.dly + 32'h0000_0001;
      end
    end
    // Contact looked at once per sampling cycle only
    if (tick_now) begin
      if (contact_in != s_reg.sampled) begin
        s_next.sampled = contact_in;
        s_next.dly = 32'h0000_0000;
        s_next.waiting = 1'b1;
        s_next.pending = 1'b0;
      end else if (s_reg.pending) begin
        s_next.applied = s_reg.sampled;
        s_next.pending = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_sample_on_tick: assert property ($changed(s_reg.sampled) |-> $past(tick_now))
    else $error("contact sampled off the sampling tick");
  a_apply_after_wait: assert property ($changed(s_reg.applied) |->
    $past(s_reg.pending) && $past(tick_now) && !$past(s_reg.waiting))
    else $error("contact state applied before delay elapsed");
  c_contact_applied: cover property ($rose(s_reg.applied));
endmodule

// *** logic/run_stop_mode_control.sv ***
// Run/stop mode controller: key, communication and contact merge with stop outputs
`timescale 1ns/1ps
`include "run_stop_consts.svh"
module run_stop_mode_control
  import run_stop_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLE_MS * 1000 * `CLK_MHZ,
  parameter int DELAY_CYCLES = `QUAL_DELAY_MS * 1000 * `CLK_MHZ,
  parameter int HOLD_CYCLES = `SET_HOLD_MS * 1000 * `CLK_MHZ,
  parameter int OP_SCREENS = `OP_SCREEN_COUNT
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire key_type keys_in,
  input wire logic direct_key_runstop_in,
  input wire logic comm_valid_in,
  input wire logic comm_run_in,
  input wire logic [2:0] contact_in,
  input wire logic [1:0] di_assign_sel_in,
  input wire logic [2:0] di_eligible_in,
  input wire logic stop_disp_on_pv_in,
  input wire logic [1:0] control_type_in,
  input wire logic [15:0] heat_stop_output_value_in,
  input wire logic [15:0] cool_stop_output_value_in,
  input wire logic [15:0] heat_mv_run_in,
  input wire logic [15:0] cool_mv_run_in,
  input wire logic valve_feedback_present_in,
  input wire logic valve_feedback_break_in,
  input wire logic [15:0] valve_feedback_input_in,
  input wire logic [1:0] valve_stop_action_in,
  input wire logic [3:0] event_run_in,
  input wire logic heater_break_alarm_run_in,
  input wire logic [15:0] transmission_run_in,
  input wire logic stop_status_on_in,
  input wire logic [1:0] hot_cold_start_sel_in,
  output logic run_mode_out,
  output logic key_setting_run_out,
  output logic menu_operation_out,
  output logic [3:0] screen_out,
  output logic stop_on_setpoint_display_out,
  output logic stop_on_measured_value_display_out,
  output logic [15:0] heat_output_out,
  output logic [15:0] cool_output_out,
  output logic valve_follow_out,
  output logic [1:0] valve_action_out,
  output logic [3:0] event_out,
  output logic heater_break_alarm_output_out,
  output logic [15:0] transmission_out,
  output logic resume_pulse_out,
  output logic [1:0] resume_mode_out
);
  // ***************************************************************
  // Contact selection and qualification
  // ***************************************************************
  ctrl_state_type s_reg;
  ctrl_state_type s_next;
  logic di_active;
  logic contact_sel;
  logic qual_closed;
  logic run_blocked;
  key_type press;
  logic on_rs_screen;
  logic hold_hit;

  if (OP_SCREENS < 1 || OP_SCREENS > 16 || 32'(`RUNSTOP_SCREEN) >= 32'(OP_SCREENS)
      || HOLD_CYCLES < 1) begin : g_chk
    $error("run_stop_mode_control: unsupported menu or hold setting");
  end

  always_comb begin
    di_active = 1'b0;
    contact_sel = 1'b0;
    if (di_assign_sel_in != 2'h0) begin
      di_active = di_eligible_in[di_assign_sel_in - 2'h1];
      contact_sel = contact_in[di_assign_sel_in - 2'h1];
    end
  end

  contact_qualifier #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_qual (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .contact_in(contact_sel),
    .closed_out(qual_closed)
  );

  assign run_blocked = di_active && !qual_closed;
  assign press = keys_in & ~s_reg.keys_prev;
  assign on_rs_screen = (s_reg.menu == MENU_OPERATION) && (s_reg.screen == `RUNSTOP_SCREEN);
  assign hold_hit = keys_in.set && !s_reg.hold_done &&
                    (s_reg.hold_cnt == 32'(HOLD_CYCLES - 1));

  // ***************************************************************
  // Menu, key setting and mode merge
  // ***************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.keys_prev = keys_in;
    if (!keys_in.set) begin
      s_next.hold_cnt = 32'h0000_0000;
      s_next.hold_done = 1'b0;
    end else if (hold_hit) begin
      s_next.hold_done = 1'b1;
      s_next.screen = 4'h0;
      s_next.menu = (s_reg.menu == MENU_MONITOR) ? MENU_OPERATION : MENU_MONITOR;
    end else if (!s_reg.hold_done) begin
      s_next.hold_cnt = s_reg.hold_cnt + 32'h0000_0001;
    end
    if (s_reg.menu == MENU_OPERATION && press.shift) begin
      s_next.screen = (s_reg.screen == 4'(OP_SCREENS - 1)) ? 4'h0 : s_reg.screen + 4'h1;
    end
    if (on_rs_screen && press.up) begin
      s_next.key_run = 1'b0;
    end else if (on_rs_screen && press.down && !run_blocked) begin
      s_next.key_run = 1'b1;
    end
    if (direct_key_runstop_in && press.direct && (s_reg.key_run || !run_blocked)) begin
      s_next.key_run = !s_reg.key_run;
    end
    if (comm_valid_in) begin
      s_next.key_run = comm_run_in;
    end
    s_next.run_mode = s_reg.key_run && (!di_active || qual_closed);
    s_next.resume_pulse = s_next.run_mode && !s_reg.run_mode;
    s_next.resume_mode = s_next.resume_pulse ? hot_cold_start_sel_in : s_reg.resume_mode;

    // Outputs follow the merged mode
    s_next.stop_on_sv = !s_next.run_mode && !stop_disp_on_pv_in;
    s_next.stop_on_pv = !s_next.run_mode && stop_disp_on_pv_in;
    s_next.valve_follow = 1'b0;
    s_next.valve_action = 2'h0;
    if (s_next.run_mode) begin
      s_next.heat_out = heat_mv_run_in;
      s_next.cool_out = cool_mv_run_in;
      s_next.events = event_run_in;
      s_next.heater_break_alarm_output = heater_break_alarm_run_in;
      s_next.transmission = transmission_run_in;
    end else begin
      s_next.heat_out = heat_stop_output_value_in;
      s_next.cool_out = (control_type_in == `CTRL_HEATCOOL) ? cool_stop_output_value_in
                                                            : `MV_RESET;
      if (control_type_in == `CTRL_POSITION) begin
        s_next.cool_out = `MV_RESET;
        if (valve_feedback_present_in && !valve_feedback_break_in) begin
          s_next.heat_out = valve_feedback_input_in;
          s_next.valve_follow = 1'b1;
        end else begin
          s_next.heat_out = `MV_RESET;
          s_next.valve_action = valve_stop_action_in;
        end
      end
      s_next.events = {`EVENT_COUNT{stop_status_on_in}};
      s_next.heater_break_alarm_output = stop_status_on_in;
      s_next.transmission = stop_status_on_in ? transmission_run_in : `MV_RESET;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign run_mode_out = s_reg.run_mode;
  assign key_setting_run_out = s_reg.key_run;
  assign menu_operation_out = (s_reg.menu == MENU_OPERATION);
  assign screen_out = s_reg.screen;
  assign stop_on_setpoint_display_out = s_reg.stop_on_sv;
  assign stop_on_measured_value_display_out = s_reg.stop_on_pv;
  assign heat_output_out = s_reg.heat_out;
  assign cool_output_out = s_reg.cool_out;
  assign valve_follow_out = s_reg.valve_follow;
  assign valve_action_out = s_reg.valve_action;
  assign event_out = s_reg.events;
  assign heater_break_alarm_output_out = s_reg.heater_break_alarm_output;
  assign transmission_out = s_reg.transmission;
  assign resume_pulse_out = s_reg.resume_pulse;
  assign resume_mode_out = s_reg.resume_mode;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // Stop-state checks skip the first edge after reset, where the registers still hold zeros
  a_contact_closed_run: assert property (
    di_active && qual_closed && s_reg.key_run |=> s_reg.run_mode)
    else $error("closed contact with run setting did not give run");
  a_open_blocks_key: assert property (
    run_blocked && !s_reg.key_run && !comm_valid_in |=> !s_reg.key_run)
    else $error("key entered run with contact open");
  a_run_needs_both: assert property (s_reg.run_mode |->
    $past(s_reg.key_run) && (!$past(di_active) || $past(qual_closed)))
    else $error("run without both run sources");
  a_stop_one_display: assert property (!s_reg.run_mode && $past(rstn_in) |->
    (s_reg.stop_on_sv != s_reg.stop_on_pv) && (s_reg.stop_on_pv == $past(stop_disp_on_pv_in)))
    else $error("stop symbol on wrong display");
  a_heat_stop_value: assert property (!s_reg.run_mode && $past(rstn_in) &&
    $past(control_type_in) != `CTRL_POSITION |->
    s_reg.heat_out == $past(heat_stop_output_value_in))
    else $error("heat output not at stop value");
  a_valve_follow: assert property (
    !s_reg.run_mode && $past(rstn_in) && $past(control_type_in) == `CTRL_POSITION
    |-> s_reg.valve_follow == ($past(valve_feedback_present_in) &&
      !$past(valve_feedback_break_in)))
    else $error("valve stop action selection wrong");
  a_event_stop_status: assert property (!s_reg.run_mode && $past(rstn_in) |->
    s_reg.heater_break_alarm_output == $past(stop_status_on_in) && s_reg.events == {4{$past(stop_status_on_in)}})
    else $error("stop status outputs wrong");
  a_resume_on_run: assert property ($rose(s_reg.run_mode) |->
    s_reg.resume_pulse && s_reg.resume_mode == $past(hot_cold_start_sel_in))
    else $error("no resume on stop to run");
  a_menu_after_hold: assert property ($rose(s_reg.menu == MENU_OPERATION) |->
    $past(s_reg.hold_cnt) == 32'(HOLD_CYCLES - 1) && $past(keys_in.set))
    else $error("operation menu opened without full hold");
  a_up_gives_stop: assert property (on_rs_screen && press.up && !comm_valid_in
    && !(direct_key_runstop_in && press.direct) |=> !s_reg.key_run)
    else $error("up key did not select stop");
  a_direct_toggles: assert property (
    direct_key_runstop_in && press.direct && s_reg.key_run && !comm_valid_in |=> !s_reg.key_run)
    else $error("direct key did not toggle");
  a_unassigned_ignored: assert property (
    di_assign_sel_in == 2'h0 && s_reg.key_run |=> s_reg.run_mode)
    else $error("contact acted while unassigned");

  c_run_mode: cover property ($rose(s_reg.run_mode));
  c_contact_stop: cover property (s_reg.run_mode ##1 !s_reg.run_mode && s_reg.key_run);
  c_menu_entry: cover property ($rose(s_reg.menu == MENU_OPERATION));
  c_direct_toggle: cover property (direct_key_runstop_in && press.direct);
endmodule

// *** verif/panel_model.sv ***
// Front panel keys and run/stop dry contacts as seen by the controller
`timescale 1ns/1ps
module panel_model
  import run_stop_pkg::*;
(
  input wire logic mclk_in,
  output key_type keys_out,
  output logic [2:0] contact_out
);
  // ****************************************
  // Key and contact actions
  // ****************************************
  initial begin
    keys_out = '0;
    contact_out = 3'h0;
  end

  // Holds one key for a number of cycles, then lets one idle cycle pass
  task automatic press(input int idx, input int cycles);
    @(negedge mclk_in);
    keys_out[idx] = 1'b1;
    repeat (cycles) @(negedge mclk_in);
    keys_out[idx] = 1'b0;
    @(negedge mclk_in);
  endtask

  // Dry contact: a clean level, closed is 1
  task automatic set_contact(input int di, input logic closed);
    @(negedge mclk_in);
    contact_out[di] = closed;
  endtask
endmodule

// *** verif/run_stop_mode_control_bench.sv ***
// Self-checking testbench for the run/stop mode controller
`timescale 1ns/1ps
module run_stop_mode_control_bench
  import run_stop_pkg::*;
;
  localparam int SAMPLE = 8;
  localparam int DELAY = 16;
  localparam int HOLD = 10;
  localparam logic [15:0] HEAT_STOP = 16'hFFCE;
  localparam logic [15:0] COOL_STOP = 16'h0032;
  localparam logic [15:0] TX_RUN = 16'h0ABC;
  localparam logic [15:0] FB_VAL = 16'h0321;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  key_type keys;
  logic [2:0] contact;
  logic direct_rs = 1'b0;
  logic comm_valid = 1'b0;
  logic comm_run = 1'b0;
  logic disp_pv = 1'b0;
  logic [1:0] di_sel = 2'h0;
  logic [1:0] ctrl = 2'h0;
  logic [2:0] di_elig = 3'h0;
  logic fb_present = 1'b0;
  logic fb_break = 1'b0;
  logic status_on = 1'b0;
  logic [1:0] hot_cold = 2'h2;
  logic [15:0] heat_stop = HEAT_STOP;
  logic [1:0] valve_act = 2'h3;
  logic [3:0] event_run = 4'hA;
  logic hba_run = 1'b1;
  logic run_mode, key_run, menu_op, stop_sv, stop_pv, follow, hba_o, resume_p;
  logic [3:0] screen, ev_o;
  logic [15:0] heat_o, cool_o, tx_o;
  logic [1:0] valve_o, resume_m, last_mode;
  int num_errors = 0;
  int samples_checked = 0;
  int pulses = 0;

  run_stop_mode_control #(.SAMPLE_CYCLES(SAMPLE), .DELAY_CYCLES(DELAY),
      .HOLD_CYCLES(HOLD), .OP_SCREENS(4)) DUT (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .keys_in(keys),
    .direct_key_runstop_in(direct_rs), .comm_valid_in(comm_valid), .comm_run_in(comm_run),
    .contact_in(contact), .di_assign_sel_in(di_sel), .di_eligible_in(di_elig),
    .stop_disp_on_pv_in(disp_pv), .control_type_in(ctrl),
    .heat_stop_output_value_in(heat_stop), .cool_stop_output_value_in(COOL_STOP),
    .heat_mv_run_in(16'h1234), .cool_mv_run_in(16'h0567),
    .valve_feedback_present_in(fb_present), .valve_feedback_break_in(fb_break),
    .valve_feedback_input_in(FB_VAL), .valve_stop_action_in(valve_act),
    .event_run_in(event_run), .heater_break_alarm_run_in(hba_run), .transmission_run_in(TX_RUN),
    .stop_status_on_in(status_on), .hot_cold_start_sel_in(hot_cold),
    .run_mode_out(run_mode), .key_setting_run_out(key_run), .menu_operation_out(menu_op),
    .screen_out(screen), .stop_on_setpoint_display_out(stop_sv),
    .stop_on_measured_value_display_out(stop_pv), .heat_output_out(heat_o),
    .cool_output_out(cool_o), .valve_follow_out(follow), .valve_action_out(valve_o),
    .event_out(ev_o), .heater_break_alarm_output_out(hba_o), .transmission_out(tx_o),
    .resume_pulse_out(resume_p), .resume_mode_out(resume_m)
  );

  panel_model u_panel (.mclk_in(mclk_in), .keys_out(keys), .contact_out(contact));

  // ****************************************
  // Shared tasks
  // ****************************************
  always #5 mclk_in = ~mclk_in;

  always @(negedge mclk_in) begin
    if (resume_p === 1'b1) begin
      pulses++;
      last_mode = resume_m;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  // Counts cycles until the actual mode reaches exp; past the bound the run is cut short
  task automatic wait_run(input logic exp, input int hi, output int n);
    n = 0;
    while (run_mode !== exp) begin
      @(negedge mclk_in);
      n++;
      if (n > hi) begin
        check(run_mode, exp);
        results();
      end
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check({run_mode, key_run, pulses[0]}, 3'b000);
    check({menu_op, screen}, 5'h00);
    check({stop_sv, stop_pv}, 2'b10);
    check({heat_o, cool_o}, {HEAT_STOP, 16'h0000});
    check({ev_o, hba_o, tx_o}, 21'h0);
  endtask

  task automatic t_menu();
    u_panel.press(4, 5);
    check(menu_op, 1'b0);
    u_panel.press(4, HOLD + 2);
    check({menu_op, screen}, 5'h10);
    u_panel.press(3, 1);
    u_panel.press(3, 1);
    check(screen, 4'h2);
  endtask

  task automatic t_keys();
    int n;
    u_panel.press(1, 1);
    check(key_run, 1'b1);
    wait_run(1'b1, 4, n);
    tick(2);
    check({pulses[3:0], last_mode}, {4'h1, hot_cold});
    check({heat_o, cool_o}, {16'h1234, 16'h0567});
    check(tx_o, TX_RUN);
    check({ev_o, hba_o, stop_sv}, 6'b101010);
    u_panel.press(2, 1);
    check(key_run, 1'b0);
    wait_run(1'b0, 4, n);
    check({heat_o, stop_sv, pulses[3:0]}, {HEAT_STOP, 1'b1, 4'h1});
  endtask

  task automatic t_direct();
    int n;
    u_panel.press(0, 1);
    check(key_run, 1'b0);
    direct_rs = 1'b1;
    u_panel.press(0, 1);
    check(key_run, 1'b1);
    u_panel.press(0, 1);
    check(key_run, 1'b0);
    wait_run(1'b0, 4, n);
  endtask

  task automatic t_contact();
    int n;
    di_sel = 2'h1;
    di_elig = 3'h1;
    u_panel.press(1, 1);
    check(key_run, 1'b0);
    u_panel.press(0, 1);
    check(key_run, 1'b0);
    comm_valid = 1'b1;
    comm_run = 1'b1;
    tick(1);
    comm_valid = 1'b0;
    tick(SAMPLE);
    check({key_run, run_mode, stop_sv}, 3'b101);
    u_panel.set_contact(0, 1'b1);
    wait_run(1'b1, DELAY + 2 * SAMPLE + 6, n);
    check(n >= DELAY + SAMPLE, 1'b1);
    u_panel.press(2, 1);
    wait_run(1'b0, 4, n);
    u_panel.press(1, 1);
    wait_run(1'b1, 4, n);
    check({key_run, run_mode}, 2'b11);
    u_panel.set_contact(0, 1'b0);
    wait_run(1'b0, DELAY + 2 * SAMPLE + 6, n);
    check(n >= DELAY + SAMPLE, 1'b1);
    di_elig = 3'h0;
    wait_run(1'b1, 4, n);
    check(run_mode, 1'b1);
    di_elig = 3'h1;
    wait_run(1'b0, 4, n);
    // Third input selected: ignored while not eligible, active once it is
    di_sel = 2'h3;
    di_elig = 3'h3;
    wait_run(1'b1, 4, n);
    check(run_mode, 1'b1);
    di_elig = 3'h4;
    wait_run(1'b0, 4, n);
    check(stop_sv, 1'b1);
  endtask

  task automatic t_outputs();
    disp_pv = 1'b1;
    tick(2);
    check({stop_sv, stop_pv}, 2'b01);
    heat_stop = 16'h0010;
    tick(2);
    check({heat_o, cool_o}, {16'h0010, 16'h0000});
    ctrl = 2'h1;
    tick(2);
    check({heat_o, cool_o}, {16'h0010, COOL_STOP});
    ctrl = 2'h2;
    fb_present = 1'b1;
    tick(2);
    check({heat_o, follow, valve_o}, {FB_VAL, 1'b1, 2'h0});
    fb_break = 1'b1;
    tick(2);
    check({heat_o, follow, valve_o}, {16'h0000, 1'b0, 2'h3});
    valve_act = 2'h1;
    tick(2);
    check(valve_o, 2'h1);
    status_on = 1'b1;
    tick(2);
    check({ev_o, hba_o, tx_o}, {4'hF, 1'b1, TX_RUN});
  endtask

  initial begin
    tick(5);
    rstn_in = 1'b1;
    tick(2);
    t_reset();
    t_menu();
    t_keys();
    t_direct();
    t_contact();
    t_outputs();
    results();
  end
endmodule
